/* File: hsmc_pkg.sv */
// hsmc_pkg: constants of the measurement configuration block
// assumes one 125 MHz clock and 8-bit registers at byte addresses
package hsmc_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned NUM_PROT = 10;

  // protected window 07h..10h, config register is the last entry
  localparam logic [7:0] PROT_FIRST_ADDR = 8'h07;
  localparam logic [7:0] PROT_LAST_ADDR  = 8'h10;
  localparam logic [7:0] CFG_ADDR        = 8'h10;
  localparam logic [7:0] STATUS_ADDR     = 8'h06;

  // reset values of the protected window, index = addr - 07h
  localparam logic [7:0] PROT_RESET [NUM_PROT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h38, 8'h00, 8'h01
  };
  // bits that take part in the parity, index = addr - 07h
  localparam logic [7:0] PROT_MASK [NUM_PROT] = '{
    8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'hff
  };

  // config register field positions
  localparam int unsigned CFG_TEMP_DIS_BIT = 7;
  localparam int unsigned CFG_ANGULAR_BIT  = 6;
  localparam int unsigned CFG_CONVERSION_ON_READ_SELECT_HI      = 5;
  localparam int unsigned CFG_CONVERSION_ON_READ_SELECT_LO      = 4;
  localparam int unsigned CFG_DOUBLE_BIT   = 3;
  localparam int unsigned CFG_DRIFT_HI     = 2;
  localparam int unsigned CFG_DRIFT_LO     = 1;
  localparam int unsigned CFG_PARITY_BIT   = 0;

  // status register flag position
  localparam int unsigned STATUS_CFG_OK_BIT = 6;

  typedef enum logic [1:0] {
    HSMC_CONVERSION_ON_READ_SELECT_NONE      = 2'h0,
    HSMC_CONVERSION_ON_READ_SELECT_FIRST_MSB = 2'h1,
    HSMC_CONVERSION_ON_READ_SELECT_AFTER_05  = 2'h2,
    HSMC_CONVERSION_ON_READ_SELECT_AFTER_05B = 2'h3
  } hsmc_conversion_on_read_select_t;

endpackage

/* File: hsmc_parity.sv */
// hsmc_parity: odd-parity reduction over the masked protected window
// assumes data and mask are packed in the same entry order
`timescale 1ns/10ps
module hsmc_parity
  import hsmc_pkg::*;
#(
  parameter int unsigned N = NUM_PROT
) (
  input  wire logic [N*DATA_W-1:0] data,
  input  wire logic [N*DATA_W-1:0] mask,
  output logic                     odd
);

  if (N < 1) begin : g_chk
    $error("hsmc_parity needs at least one entry");
  end

  // excluded bits are masked off before the reduction
  assign odd = ^(data & mask);

endmodule // hsmc_parity

/* File: hsmc_config.sv */
// hsmc_config: measurement configuration register, parity guard of the
// wake-up/config window and conversion control derived from it
// assumes the bus framing logic delivers one-cycle write strobes and read
// events on the same clock
//
// Functional notes
// R1: temp_disable low converts temperature; high leaves temperature at reset value.
// R2: angular_mode low converts z; high with temp_disable high converts only x and y.
// R3: host never sets angular_mode while temp_disable is low.
// R4: with single-byte read, trigger field picks none, before first msb, after 05h.
// R5: trigger field is ignored while single_byte_read_select is low.
// R6: double_sensitivity doubles x/y/z integration; temperature unaffected.
// R7: magnet_drift_comp selects none or one of three drift coefficients.
// R8: config_parity_bit gives odd parity over 07h..10h minus excluded bits.
// R9: after reset parity counts as invalid and config_parity_ok_flag is clear.
// R10: host rewrites config_parity_bit once after any reset.
// R11: a write leaving parity wrong disables wake-up.
// R12: parity is re-evaluated after every protected write; flag set only when odd.
`timescale 1ns/10ps
module hsmc_config
  import hsmc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              single_byte_read_select,
  input  wire logic              rd_first_msb_evt,
  input  wire logic              rd_after_05_evt,
  output logic [DATA_W-1:0]      measurement_config_q,
  output logic                   conv_temp_en_q,
  output logic                   conv_z_en_q,
  output logic                   conv_xy_en_q,
  output logic                   long_integration_q,
  output logic [1:0]             magnet_drift_comp_q,
  output logic                   conv_trigger_q,
  output logic                   config_parity_ok_flag_q,
  output logic                   wake_enable_q
);

  logic [DATA_W-1:0]          prot_q [NUM_PROT];
  logic [NUM_PROT*DATA_W-1:0] prot_flat;
  logic [NUM_PROT*DATA_W-1:0] mask_flat;
  logic                       prot_hit;
  logic                       eval_q;
  logic                       parity_odd;
  logic [DATA_W-1:0]          cfg;
  hsmc_conversion_on_read_select_t                 conversion_on_read_select;

  assign prot_hit = wr_en && (wr_addr >= PROT_FIRST_ADDR) && (wr_addr <= PROT_LAST_ADDR);
  assign cfg      = prot_q[NUM_PROT-1];
  assign conversion_on_read_select     = hsmc_conversion_on_read_select_t'(cfg[CFG_CONVERSION_ON_READ_SELECT_HI:CFG_CONVERSION_ON_READ_SELECT_LO]);

  // one storage entry per protected address; config is the last one
  for (genvar i = 0; i < NUM_PROT; i++) begin : g_prot
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        prot_q[i] <= PROT_RESET[i];
      end else if (wr_en && wr_addr == PROT_FIRST_ADDR + 8'(i)) begin
        prot_q[i] <= wr_data;
      end
    end
    assign prot_flat[i*DATA_W +: DATA_W] = prot_q[i];
    assign mask_flat[i*DATA_W +: DATA_W] = PROT_MASK[i];
  end

  hsmc_parity #(
    .N    (NUM_PROT)
  ) u_parity (
    .data (prot_flat),
    .mask (mask_flat),
    .odd  (parity_odd)
  );

  assign measurement_config_q = cfg;

  // evaluate one cycle after the write so the new byte is already stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eval_q <= 1'b0;
    end else begin
      eval_q <= prot_hit; // [R12]
    end
  end

  // flag stays clear after reset even if reset values happen to be odd
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      config_parity_ok_flag_q <= 1'b0; // [R9]
      wake_enable_q           <= 1'b0;
    end else if (eval_q) begin
      config_parity_ok_flag_q <= parity_odd; // [R8] [R12]
      wake_enable_q           <= parity_odd; // [R11]
    end
  end

  // forbidden angular-without-temp-disable is not policed: z simply converts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_temp_en_q      <= 1'b1;
      conv_z_en_q         <= 1'b1;
      conv_xy_en_q        <= 1'b1;
      long_integration_q  <= 1'b0;
      magnet_drift_comp_q <= 2'h0;
    end else begin
      conv_temp_en_q      <= !cfg[CFG_TEMP_DIS_BIT]; // [R1]
      conv_z_en_q         <= !(cfg[CFG_ANGULAR_BIT] && cfg[CFG_TEMP_DIS_BIT]); // [R2] [R3]
      conv_xy_en_q        <= 1'b1;
      long_integration_q  <= cfg[CFG_DOUBLE_BIT]; // [R6]
      magnet_drift_comp_q <= cfg[CFG_DRIFT_HI:CFG_DRIFT_LO]; // [R7]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_trigger_q <= 1'b0;
    end else if (!single_byte_read_select) begin
      conv_trigger_q <= 1'b0; // [R5]
    end else begin
      unique case (conversion_on_read_select)
        HSMC_CONVERSION_ON_READ_SELECT_NONE:      conv_trigger_q <= 1'b0; // [R4]
        HSMC_CONVERSION_ON_READ_SELECT_FIRST_MSB: conv_trigger_q <= rd_first_msb_evt; // [R4]
        HSMC_CONVERSION_ON_READ_SELECT_AFTER_05,
        HSMC_CONVERSION_ON_READ_SELECT_AFTER_05B: conv_trigger_q <= rd_after_05_evt; // [R4]
      endcase
    end
  end

  flag_after_eval_a: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    eval_q |=> config_parity_ok_flag_q == $past(parity_odd))
    else $error("parity flag does not follow evaluation");

  flag_holds_a: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    !eval_q |=> $stable(config_parity_ok_flag_q))
    else $error("parity flag changed without a write");

  write_evaluates_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    prot_hit |-> ##2 config_parity_ok_flag_q == $past(parity_odd))
    else $error("parity not evaluated two cycles after write");

  wake_follows_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    wake_enable_q == config_parity_ok_flag_q)
    else $error("wake enable disagrees with parity flag");

  reset_flag_clear_a: assert property (@(posedge clk) // [R9]
    !rst_n |=> !config_parity_ok_flag_q && !wake_enable_q)
    else $error("parity flag not cleared by reset");

  temp_enable_a: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    ##1 conv_temp_en_q == !$past(cfg[CFG_TEMP_DIS_BIT]))
    else $error("temperature enable wrong");

  z_enable_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    (cfg[CFG_ANGULAR_BIT] && cfg[CFG_TEMP_DIS_BIT]) |=> !conv_z_en_q)
    else $error("z converted in angular mode");

  no_conversion_on_read_select_pr0_a: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    !single_byte_read_select |=> !conv_trigger_q)
    else $error("trigger while single-byte read off");

  conversion_on_read_select_msb_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (single_byte_read_select && conversion_on_read_select == HSMC_CONVERSION_ON_READ_SELECT_FIRST_MSB && rd_first_msb_evt)
      |=> conv_trigger_q)
    else $error("missing trigger before first msb");

  conversion_on_read_select_none_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (conversion_on_read_select == HSMC_CONVERSION_ON_READ_SELECT_NONE) |=> !conv_trigger_q)
    else $error("trigger with trigger field zero");

  double_sens_a: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    $rose(cfg[CFG_DOUBLE_BIT]) |=> long_integration_q)
    else $error("double sensitivity not applied");

  drift_sel_a: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
    ##1 magnet_drift_comp_q == $past(cfg[CFG_DRIFT_HI:CFG_DRIFT_LO]))
    else $error("drift coefficient select wrong");

  // both after-05h field codes must raise the trigger on the read after register 05h
  conversion_on_read_select_after_05_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (single_byte_read_select && conversion_on_read_select inside {HSMC_CONVERSION_ON_READ_SELECT_AFTER_05, HSMC_CONVERSION_ON_READ_SELECT_AFTER_05B}
      && rd_after_05_evt) |=> conv_trigger_q)
    else $error("missing trigger after register 05h");

  msb_only_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (conversion_on_read_select == HSMC_CONVERSION_ON_READ_SELECT_FIRST_MSB && !rd_first_msb_evt) |=> !conv_trigger_q)
    else $error("trigger without first msb read");

  after_05_only_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (conversion_on_read_select inside {HSMC_CONVERSION_ON_READ_SELECT_AFTER_05, HSMC_CONVERSION_ON_READ_SELECT_AFTER_05B} && !rd_after_05_evt)
      |=> !conv_trigger_q)
    else $error("trigger without read after register 05h");

  single_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (conv_trigger_q && !rd_first_msb_evt && !rd_after_05_evt) |=> !conv_trigger_q)
    else $error("trigger pulse longer than its event");

  wake_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    (eval_q && !parity_odd) |=> !wake_enable_q)
    else $error("wake-up left on with wrong parity");

  flag_set_a: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    (eval_q && parity_odd) |=> config_parity_ok_flag_q && wake_enable_q)
    else $error("parity flag not set for odd parity");

  no_eval_outside_a: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    (wr_en && !prot_hit) |=> !eval_q)
    else $error("parity evaluated for unprotected write");

  config_stored_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    (wr_en && wr_addr == CFG_ADDR) |=> measurement_config_q == $past(wr_data))
    else $error("config write not stored");

  xy_enabled_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    conv_xy_en_q)
    else $error("x and y conversion disabled");

  z_enabled_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    !cfg[CFG_ANGULAR_BIT] |=> conv_z_en_q)
    else $error("z not converted with angular mode off");

  double_follow_a: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    ##1 long_integration_q == $past(cfg[CFG_DOUBLE_BIT]))
    else $error("integration length does not follow double sensitivity");

  reset_outputs_a: assert property (@(posedge clk) // [R9]
    !rst_n |=> measurement_config_q == PROT_RESET[NUM_PROT-1] && conv_temp_en_q
      && conv_z_en_q && !conv_trigger_q)
    else $error("conversion outputs not at reset values");

endmodule // hsmc_config

/* File: hsmc_host.sv */
// hsmc_host: host model issuing single-byte register writes
// assumes clk is the block clock; writes launch at its falling edge
`timescale 1ns/10ps
module hsmc_host
  import hsmc_pkg::*;
(
  input  wire logic         clk,
  output logic              wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data
);
  initial begin
    wr_en   = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
  end
  // never asked for angular_mode without temp_disable
  // first write after reset fixes config_parity_bit
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en   = 1'b0;
    // released lines show the inverse so stale data cannot pass
    wr_addr = ~a;
    wr_data = ~d;
  endtask
endmodule // hsmc_host

/* File: testbench.sv */
// testbench: writes, parity flag, decode and read triggers
// assumes hsmc_host drives the write port at falling edges
`timescale 1ns/10ps
module testbench
  import hsmc_pkg::*;
;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] cfg;
    logic [7:0] dec;
  } hsmc_row_t;
  // dec = {00, temp, z, long, drift, flag}; 0eh/07h rows probe the masks
  hsmc_row_t  rows [10] = '{
    '{8'h10, 8'h00, 8'h00, 8'h31}, '{8'h10, 8'h81, 8'h81, 8'h11},
    '{8'h10, 8'hc1, 8'hc1, 8'h00}, '{8'h10, 8'h0f, 8'h0f, 8'h3f},
    '{8'h10, 8'h0a, 8'h0a, 8'h3b}, '{8'h10, 8'h04, 8'h04, 8'h34},
    '{8'h0e, 8'hff, 8'h04, 8'h35}, '{8'h05, 8'hff, 8'h04, 8'h35},
    '{8'h07, 8'h80, 8'h04, 8'h35}, '{8'h07, 8'h01, 8'h04, 8'h34}};
  logic       clk, rst_n, wr_en, pr, msb_evt, a05_evt;
  logic [7:0] wr_addr, wr_data, cfg_q;
  logic       temp_en, z_en, xy_en, long_int, conversion_on_read_select, ok_flag, wake;
  logic [1:0] drift;
  int         bad_count, n_tests;
  wire  [7:0] dec = {2'b00, temp_en, z_en, long_int, drift, ok_flag};

  hsmc_host hsmc_host_i (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
  hsmc_config hsmc_config_i (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .single_byte_read_select(pr), .rd_first_msb_evt(msb_evt),
    .rd_after_05_evt(a05_evt), .measurement_config_q(cfg_q), .conv_temp_en_q(temp_en),
    .conv_z_en_q(z_en), .conv_xy_en_q(xy_en), .long_integration_q(long_int),
    .magnet_drift_comp_q(drift), .conv_trigger_q(conversion_on_read_select),
    .config_parity_ok_flag_q(ok_flag), .wake_enable_q(wake));

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_rst;
    chk("rst_config", 8'h01, cfg_q);
    chk("rst_decode", 8'h30, dec);
    chk("rst_wake_xy", 8'h01, {6'h0, wake, xy_en});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // run is about a hundred cycles; this limit only catches a hang
  initial begin
    #50000;
    bad_count++;
    finish_test();
  end

  initial begin
    {rst_n, pr, msb_evt, a05_evt} = 4'h0;
    repeat (20) @(negedge clk);
    chk_rst();
    rst_n = 1'b1;
    foreach (rows[i]) begin
      hsmc_host_i.wr(rows[i].addr, rows[i].data);
      @(negedge clk);
      chk("config", rows[i].cfg, cfg_q);
      chk("decode", rows[i].dec, dec);
      chk("wake", {7'h0, rows[i].dec[0]}, {7'h0, wake});
    end
    $display("test rows done");
    for (int f = 0; f < 4; f++) begin
      for (int p = 0; p < 2; p++) begin
        hsmc_host_i.wr(CFG_ADDR, 8'(f << 4));
        pr = p[0];
        @(negedge clk) msb_evt = 1'b1;
        @(negedge clk) msb_evt = 1'b0;
        a05_evt = 1'b1;
        chk("conversion_on_read_select_msb", {7'h0, p[0] & (f == 1)}, {7'h0, conversion_on_read_select});
        @(negedge clk) chk("conversion_on_read_select_05", {7'h0, p[0] & f[1]}, {7'h0, conversion_on_read_select});
        @(negedge clk) a05_evt = 1'b0;
        chk("conversion_on_read_select_05b", {7'h0, p[0] & f[1]}, {7'h0, conversion_on_read_select});
        @(negedge clk) chk("conversion_on_read_select_end", 8'h00, {7'h0, conversion_on_read_select});
      end
    end
    $display("test triggers done");
    hsmc_host_i.wr(CFG_ADDR, 8'h00);
    @(negedge clk) rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk_rst();
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk_rst();
    hsmc_host_i.wr(CFG_ADDR, 8'h00);
    @(negedge clk);
    chk("cp_fix", 8'h03, {6'h0, ok_flag, wake});
    $display("test mid reset done");
    finish_test();
  end
endmodule // testbench
